// ==== gpio_port.sv ====
// Eight-pin GPIO port: interrupt detection, enable mask, status, pad configuration and lock
// Functional notes
// [RULE1] Only enabled sources reach the interrupt output
// [RULE2] Nine sources: pins 0 to 7, DMA
// [RULE3] Raw and masked status both readable
// [RULE4] Status bits match enable mask positions
// [RULE5] Falling, rising, both, low, high triggers
// [RULE6] Optional separate interrupt line per pin
// [RULE7] Summary goes to pin-0 line when combined
// [RULE8] Trigger readback includes separate-line option
// [RULE9] Pins held stable during trigger changes
// [RULE10] Eight-bit mask selects pins to configure
// [RULE11] Drive 2, 4, 8 mA, 8 mA slew-limited
// [RULE12] Optional 6, 10, 12 mA drive settings
// [RULE13] Push-pull, pull-up, pull-down, open-drain, analog
// [RULE14] Inputs affected only by pull choice
// [RULE15] Optional wake-high and wake-low pin types
// [RULE16] Drive and type read back as written
// [RULE17] Protected pins need unlock and commit first
// [RULE18] Software clears selected sources by mask
// [RULE19] Masked equals raw AND enable; output ORs
// [RULE20] Edges from sample compare; levels follow pin
//
// Local design decisions: the register addresses and the APB slave port.
module gpio_port #(
   parameter logic [7:0]  PROTECTED_PINS = 8'h0f,
   parameter logic [31:0] UNLOCK_KEY     = gpio_port_pkg::RST_UNLOCK_KEY,
   parameter bit          HAS_DISCRETE   = 1'b1,
   parameter bit          HAS_EXT_DRIVE  = 1'b1,
   parameter bit          HAS_WAKE       = 1'b1,
   parameter int          PINS           = gpio_port_pkg::PIN_COUNT
) (
   // Clock and reset
   input  wire logic                                   pclk,
   input  wire logic                                   presetn,
   // APB slave
   input  wire logic [gpio_port_pkg::ADDR_W-1:0]       paddr,
   input  wire logic                                   psel,
   input  wire logic                                   penable,
   input  wire logic                                   pwrite,
   input  wire logic [31:0]                            pwdata,
   output logic [31:0]                                 prdata,
   output logic                                        pready,
   output logic                                        pslverr,
   // Port pins and DMA activity
   input  wire logic [gpio_port_pkg::PIN_COUNT-1:0]    pin_in,
   input  wire logic                                   dma_event,
   // Pad settings
   output gpio_port_pkg::pad_cfg_t                     pad_cfg [gpio_port_pkg::PIN_COUNT],
   output gpio_port_pkg::pad_ctl_t                     pad_ctl [gpio_port_pkg::PIN_COUNT],
   // Interrupt lines
   output logic                                        port_irq,
   output logic [gpio_port_pkg::PIN_COUNT-1:0]         pin_irq
);
   import gpio_port_pkg::*;

   // Refuse geometries the eight-bit pin mask cannot serve
   if (PINS != PIN_COUNT) begin : g_bad_pins
      $error("gpio_port supports exactly eight pins");
   end

   // Registers
   logic [SRC_COUNT-1:0]   int_enable;
   logic [SRC_COUNT-1:0]   edge_flag;
   logic [PIN_COUNT-1:0]   pin_select;
   logic [PIN_INDEX_W-1:0] pin_index;
   logic [2:0]             trig_type [PIN_COUNT];
   logic                   discrete;
   logic                   unlocked;
   logic [PIN_COUNT-1:0]   commit_control_register;

   // Detection and status nets
   logic [PIN_COUNT-1:0] edge_hit;
   logic [PIN_COUNT-1:0] level_active;
   logic [PIN_COUNT-1:0] is_level;
   logic [SRC_COUNT-1:0] raw_status;
   logic [SRC_COUNT-1:0] masked_status;

   // Bus decode nets
   logic        setup_phase;
   logic        write_access;
   logic        addr_mapped;
   logic [31:0] next_rdata;
   logic        wr_enable;
   logic        wr_clear;
   logic        wr_select;
   logic        wr_index;
   logic        wr_trig;
   logic        wr_pad;
   logic        wr_lock;
   logic        wr_commit;

   // Decoded write fields
   logic [2:0] wr_trig_val;
   logic       trig_legal;
   logic [2:0] wr_drive_val;
   logic [2:0] wr_type_val;
   logic       drive_legal;
   logic       type_legal;

   // Zero-wait slave: every access completes in its first access cycle
   assign pready       = 1'b1;
   assign setup_phase  = psel && !penable;
   assign write_access = psel && penable && pwrite;

   // Address decode; anything else answers with an error
   always_comb begin
      unique case (paddr)
         OFS_INT_ENABLE, OFS_RAW_STATUS, OFS_MSK_STATUS, OFS_INT_CLEAR,
         OFS_PIN_SELECT, OFS_PIN_INDEX, OFS_TRIG_CFG, OFS_PAD_CFG,
         OFS_LOCK, OFS_COMMIT: addr_mapped = 1'b1;
         default:              addr_mapped = 1'b0;
      endcase
   end

   // Write strobes, one per writable register
   assign wr_enable = write_access && (paddr == OFS_INT_ENABLE);
   assign wr_clear  = write_access && (paddr == OFS_INT_CLEAR);
   assign wr_select = write_access && (paddr == OFS_PIN_SELECT);
   assign wr_index  = write_access && (paddr == OFS_PIN_INDEX);
   assign wr_trig   = write_access && (paddr == OFS_TRIG_CFG);
   assign wr_pad    = write_access && (paddr == OFS_PAD_CFG);
   assign wr_lock   = write_access && (paddr == OFS_LOCK);
   assign wr_commit = write_access && (paddr == OFS_COMMIT);

   // Write field extraction and legality of encodings
   assign wr_trig_val  = pwdata[TRIG_TYPE_LSB +: 3];
   assign wr_drive_val = pwdata[PAD_DRIVE_LSB +: 3];
   assign wr_type_val  = pwdata[PAD_TYPE_LSB +: 3];
   assign trig_legal   = (wr_trig_val <= TRIG_HIGH_LVL);                                // [RULE5]
   assign drive_legal  = (wr_drive_val <= drive_8ma_slew_limited)                       // [RULE11]
                       || (HAS_EXT_DRIVE && (wr_drive_val <= DRIVE_12MA));               // [RULE12]
   assign type_legal   = (wr_type_val <= TYPE_ANALOG)                                   // [RULE13]
                       || (HAS_WAKE && (wr_type_val <= TYPE_WAKE_LOW));                  // [RULE15]

   // Per-pin detectors
   for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
      gpio_pin_detect u_detect (
         .pclk         (pclk),
         .presetn      (presetn),
         .pin_async    (pin_in[n]),
         .trig         (trig_type[n]),
         .edge_hit     (edge_hit[n]),
         .level_active (level_active[n]),
         .is_level     (is_level[n])
      );
   end

   // Interrupt enable mask, one bit per source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_enable <= RST_INT_ENABLE;
      end else if (wr_enable) begin
         int_enable <= pwdata[SRC_COUNT-1:0]; // [RULE1]
      end
   end

   // Sticky edge and DMA flags; a new event in the clear cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_flag <= '0;
      end else begin
         for (int n = 0; n < PIN_COUNT; n++) begin
            if (edge_hit[n]) begin
               edge_flag[n] <= 1'b1; // [RULE20]
            end else if ((wr_clear && pwdata[n]) || (wr_trig && pin_select[n])) begin
               edge_flag[n] <= 1'b0; // [RULE18]
            end
         end
         if (dma_event) begin
            edge_flag[DMA_SRC] <= 1'b1; // [RULE2]
         end else if (wr_clear && pwdata[DMA_SRC]) begin
            edge_flag[DMA_SRC] <= 1'b0; // [RULE18]
         end
      end
   end

   // Raw view: level pins follow the pin, edge pins show the sticky flag
   always_comb begin
      for (int n = 0; n < PIN_COUNT; n++) begin
         raw_status[n] = is_level[n] ? level_active[n] : edge_flag[n]; // [RULE20]
      end
      raw_status[DMA_SRC] = edge_flag[DMA_SRC]; // [RULE2]
   end

   // Masked view and the combined port interrupt
   assign masked_status = raw_status & int_enable; // [RULE19]
   assign port_irq      = |masked_status;          // [RULE1]

   // Separate pin lines; summary rides the pin-0 line when combined
   always_comb begin
      pin_irq = '0;
      if (HAS_DISCRETE) begin
         pin_irq = masked_status[PIN_COUNT-1:0];           // [RULE6]
         if (!discrete) begin
            pin_irq[0] = port_irq;                         // [RULE7]
         end
      end
   end

   // Pin selection mask and readback index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_select <= RST_PIN_SELECT;
         pin_index  <= '0;
      end else begin
         if (wr_select) begin
            pin_select <= pwdata[PIN_COUNT-1:0]; // [RULE10]
         end
         if (wr_index) begin
            pin_index <= pwdata[PIN_INDEX_W-1:0];
         end
      end
   end

   // Trigger settings; an illegal code leaves the pin unchanged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int n = 0; n < PIN_COUNT; n++) begin
            trig_type[n] <= RST_TRIG;
         end
      end else if (wr_trig && trig_legal) begin
         for (int n = 0; n < PIN_COUNT; n++) begin
            if (pin_select[n]) begin
               trig_type[n] <= wr_trig_val; // [RULE5] [RULE10]
            end
         end
      end
   end

   // Separate-line option; absent ports keep it off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         discrete <= 1'b0;
      end else if (wr_trig) begin
         discrete <= HAS_DISCRETE && pwdata[TRIG_DISCRETE_BIT]; // [RULE6]
      end
   end

   // Lock: the key opens it, any other value closes it again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlocked <= 1'b0;
      end else if (wr_lock) begin
         unlocked <= (pwdata == UNLOCK_KEY); // [RULE17]
      end
   end

   // Commit bits change only while unlocked; protected pins start uncommitted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         commit_control_register <= ~PROTECTED_PINS;
      end else if (wr_commit && unlocked) begin
         commit_control_register <= pwdata[PIN_COUNT-1:0] | ~PROTECTED_PINS; // [RULE17]
      end
   end

   // Pad settings stored as written, per selected and committed pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int n = 0; n < PIN_COUNT; n++) begin
            pad_cfg[n] <= RST_PAD;
         end
      end else if (wr_pad && drive_legal && type_legal) begin
         for (int n = 0; n < PIN_COUNT; n++) begin
            if (pin_select[n] && commit_control_register[n]) begin // [RULE10] [RULE17]
               pad_cfg[n].drive <= wr_drive_val;                    // [RULE11]
               pad_cfg[n].ptype <= wr_type_val;                     // [RULE13]
            end
         end
      end
   end

   // Decoded pad controls; pulls act whatever the pin direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int n = 0; n < PIN_COUNT; n++) begin
            pad_ctl[n] <= '0;
         end
      end else begin
         for (int n = 0; n < PIN_COUNT; n++) begin
            pad_ctl[n].pull_up    <= (pad_cfg[n].ptype == type_push_pull_pullup);   // [RULE14]
            pad_ctl[n].pull_down  <= (pad_cfg[n].ptype == type_push_pull_pulldown); // [RULE14]
            pad_ctl[n].open_drain <= (pad_cfg[n].ptype == type_open_drain);         // [RULE13]
            pad_ctl[n].analog     <= (pad_cfg[n].ptype == TYPE_ANALOG);             // [RULE13]
            pad_ctl[n].wake       <= (pad_cfg[n].ptype == TYPE_WAKE_HIGH)
                                   || (pad_cfg[n].ptype == TYPE_WAKE_LOW);          // [RULE15]
            pad_ctl[n].wake_high  <= (pad_cfg[n].ptype == TYPE_WAKE_HIGH);          // [RULE15]
            pad_ctl[n].slew_limit <= (pad_cfg[n].drive == drive_8ma_slew_limited);  // [RULE11]
         end
      end
   end

   // Read mux; unused bits read zero
   always_comb begin
      next_rdata = '0;
      unique case (paddr)
         OFS_INT_ENABLE: next_rdata[SRC_COUNT-1:0] = int_enable;
         OFS_RAW_STATUS: next_rdata[SRC_COUNT-1:0] = raw_status;     // [RULE3] [RULE4]
         OFS_MSK_STATUS: next_rdata[SRC_COUNT-1:0] = masked_status;  // [RULE3] [RULE4]
         OFS_PIN_SELECT: next_rdata[PIN_COUNT-1:0] = pin_select;
         OFS_PIN_INDEX:  next_rdata[PIN_INDEX_W-1:0] = pin_index;
         OFS_TRIG_CFG: begin
            next_rdata[TRIG_TYPE_LSB +: 3]  = trig_type[pin_index];  // [RULE8]
            next_rdata[TRIG_DISCRETE_BIT]   = discrete;              // [RULE8]
         end
         OFS_PAD_CFG: begin
            next_rdata[PAD_DRIVE_LSB +: 3] = pad_cfg[pin_index].drive; // [RULE16]
            next_rdata[PAD_TYPE_LSB +: 3]  = pad_cfg[pin_index].ptype; // [RULE16]
         end
         OFS_LOCK:       next_rdata[0] = !unlocked;
         OFS_COMMIT:     next_rdata[PIN_COUNT-1:0] = commit_control_register;
         default:        next_rdata = '0;
      endcase
   end

   // Read data and error are captured in setup so they stand through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata  <= pwrite ? 32'h00000000 : next_rdata;
         pslverr <= !addr_mapped;
      end
   end

endmodule : gpio_port

// ==== gpio_port_pkg.sv ====
// Package: register map, field layout, encodings and pad carrier types of the GPIO port
package gpio_port_pkg;

   // Port geometry
   localparam int PIN_COUNT = 8;
   localparam int SRC_COUNT = 9;
   localparam int DMA_SRC   = 8;
   localparam int ADDR_W    = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_RAW_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MSK_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INT_CLEAR  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_PIN_SELECT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PIN_INDEX  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_TRIG_CFG   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PAD_CFG    = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_LOCK       = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_COMMIT     = 8'h24;

   // Field positions
   localparam int TRIG_TYPE_LSB     = 0;
   localparam int TRIG_DISCRETE_BIT = 3;
   localparam int PAD_DRIVE_LSB     = 0;
   localparam int PAD_TYPE_LSB      = 4;
   localparam int PIN_INDEX_W       = 3;

   // Trigger encodings
   localparam logic [2:0] TRIG_FALLING   = 3'h0;
   localparam logic [2:0] TRIG_RISING    = 3'h1;
   localparam logic [2:0] TRIG_BOTH      = 3'h2;
   localparam logic [2:0] TRIG_LOW_LEVEL = 3'h3;
   localparam logic [2:0] TRIG_HIGH_LVL  = 3'h4;

   // Drive strength encodings
   localparam logic [2:0] DRIVE_2MA              = 3'h0;
   localparam logic [2:0] DRIVE_4MA              = 3'h1;
   localparam logic [2:0] DRIVE_8MA              = 3'h2;
   localparam logic [2:0] drive_8ma_slew_limited = 3'h3;
   localparam logic [2:0] DRIVE_6MA              = 3'h4;
   localparam logic [2:0] DRIVE_10MA             = 3'h5;
   localparam logic [2:0] DRIVE_12MA             = 3'h6;

   // Pin type encodings
   localparam logic [2:0] type_push_pull          = 3'h0;
   localparam logic [2:0] type_push_pull_pullup   = 3'h1;
   localparam logic [2:0] type_push_pull_pulldown = 3'h2;
   localparam logic [2:0] type_open_drain         = 3'h3;
   localparam logic [2:0] TYPE_ANALOG             = 3'h4;
   localparam logic [2:0] TYPE_WAKE_HIGH          = 3'h5;
   localparam logic [2:0] TYPE_WAKE_LOW           = 3'h6;

   // Stored pad setting of one pin, as written
   typedef struct packed {
      logic [2:0] ptype;
      logic [2:0] drive;
   } pad_cfg_t;

   // Decoded pad controls of one pin
   typedef struct packed {
      logic pull_up;
      logic pull_down;
      logic open_drain;
      logic analog;
      logic wake;
      logic wake_high;
      logic slew_limit;
   } pad_ctl_t;

   // Reset values
   localparam logic [SRC_COUNT-1:0] RST_INT_ENABLE = 9'h000;
   localparam logic [PIN_COUNT-1:0] RST_PIN_SELECT = 8'h00;
   localparam logic [2:0]           RST_TRIG       = TRIG_FALLING;
   localparam pad_cfg_t             RST_PAD        = '{ptype: type_push_pull, drive: DRIVE_2MA};
   localparam logic [31:0]          RST_UNLOCK_KEY = 32'h0000a5c3;

endpackage : gpio_port_pkg

// ==== gpio_pin_detect.sv ====
// Per-pin input synchroniser with edge and level trigger detection
module gpio_pin_detect (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Pin and trigger setting
   input  wire logic       pin_async,
   input  wire logic [2:0] trig,
   // Detection results
   output logic            edge_hit,
   output logic            level_active,
   output logic            is_level
);
   import gpio_port_pkg::*;

   logic sync_a;
   logic sync_b;
   logic prev;
   logic prev_valid;

   // Two-stage synchroniser; only sync_b is looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= pin_async;
         sync_b <= sync_a;
      end
   end

   // Previous sample; prev_valid masks only the first cycle, so a pin high from reset gives a rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev       <= 1'b0;
         prev_valid <= 1'b0;
      end else begin
         prev       <= sync_b;
         prev_valid <= 1'b1;
      end
   end

   // Qualify transitions and levels by the trigger setting
   always_comb begin
      is_level     = (trig == TRIG_LOW_LEVEL) || (trig == TRIG_HIGH_LVL);
      level_active = (trig == TRIG_HIGH_LVL) ? sync_b : ((trig == TRIG_LOW_LEVEL) && !sync_b); // [RULE20]
      unique case (trig)
         TRIG_FALLING: edge_hit = prev_valid && prev && !sync_b;    // [RULE20]
         TRIG_RISING:  edge_hit = prev_valid && !prev && sync_b;    // [RULE20]
         TRIG_BOTH:    edge_hit = prev_valid && (prev != sync_b);   // [RULE20]
         default:      edge_hit = 1'b0;
      endcase
   end

endmodule : gpio_pin_detect

// ==== gpio_port_monitor.sv ====
// Checker: properties on the GPIO port's ports
module gpio_port_monitor (
   // Clock and reset
   input wire logic                               pclk,
   input wire logic                               presetn,
   // APB
   input wire logic [gpio_port_pkg::ADDR_W-1:0]   paddr,
   input wire logic                               psel,
   input wire logic                               penable,
   input wire logic                               pwrite,
   input wire logic [31:0]                        pwdata,
   input wire logic [31:0]                        prdata,
   input wire logic                               pready,
   input wire logic                               pslverr,
   // Pins and pads
   input wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_in,
   input wire logic                               dma_event,
   input wire gpio_port_pkg::pad_cfg_t            pad_cfg [gpio_port_pkg::PIN_COUNT],
   input wire gpio_port_pkg::pad_ctl_t            pad_ctl [gpio_port_pkg::PIN_COUNT],
   // Interrupt lines
   input wire logic                               port_irq,
   input wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   import gpio_port_pkg::*;

   logic       wr_go;
   logic       rd_setup;
   logic [8:0] en_q;
   logic       opt_q;

   // Completed writes and read setups
   assign wr_go    = psel && penable && pwrite && !pslverr;
   assign rd_setup = psel && !penable && !pwrite;

   // Enable mask shadow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) en_q <= 9'h000;
      else if (wr_go && paddr == OFS_INT_ENABLE) en_q <= pwdata[8:0];
   end

   // Line option shadow; every trigger write stores it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) opt_q <= 1'b0;
      else if (wr_go && paddr == OFS_TRIG_CFG) opt_q <= pwdata[3];
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   status_read_a: assert property (rd_setup && paddr == OFS_RAW_STATUS |=> !pslverr && prdata[31:9] == 23'h0)
      else $error("raw status upper bits set");
   clear_read_a: assert property (rd_setup && paddr == OFS_INT_CLEAR |=> prdata == 32'h0)
      else $error("clear reads nonzero");
   enable_gate_a: assert property (port_irq |-> en_q != 9'h000)
      else $error("irq with all sources off");
   dma_source_a: assert property (dma_event && en_q[8] && !(wr_go && paddr == OFS_INT_ENABLE) |=> port_irq)
      else $error("DMA did not raise irq");
   masked_read_a: assert property (rd_setup && paddr == OFS_MSK_STATUS |=> (prdata[8:0] & ~en_q) == 9'h000)
      else $error("masked shows disabled source");
   summary_route_a: assert property (!opt_q |-> pin_irq[0] == port_irq)
      else $error("summary not on pin 0 line");
   line_subset_a: assert property (pin_irq != 8'h00 |-> port_irq)
      else $error("pin line without port irq");
   pad_decode_a: assert property (1'b1 |=>
      pad_ctl[7].open_drain == ($past(pad_cfg[7].ptype) == type_open_drain)
      && pad_ctl[7].pull_up == ($past(pad_cfg[7].ptype) == type_push_pull_pullup)
      && pad_ctl[7].slew_limit == ($past(pad_cfg[7].drive) == drive_8ma_slew_limited))
      else $error("pad controls off setting");
   pad_write_a: assert property (!$stable(pad_cfg[7]) |-> $past(psel && penable && pwrite && paddr == OFS_PAD_CFG))
      else $error("pad changed without write");

   // Scenarios
   dma_irq_c: cover property (dma_event && en_q[8]);
   line_on_c: cover property ($rose(port_irq) && opt_q);
   pad_chg_c: cover property (!$stable(pad_cfg[7]));
endmodule : gpio_port_monitor

// ==== gpio_pin_model.sv ====
// Partner: external pins and DMA activity strobe
module gpio_pin_model (
   // Clock
   input  wire logic pclk,
   // Pin side
   output logic [7:0] pin_in,
   output logic       dma_event
);
   timeunit 1ns;
   timeprecision 1ns;

   // Pins idle low
   initial begin
      pin_in = 8'h00;
      dma_event = 1'b0;
   end

   // Levels change only between trigger writes
   task automatic drive_pins(input logic [7:0] v);
      @(posedge pclk);
      pin_in <= v;
   endtask : drive_pins

   // One-cycle activity strobe
   task automatic pulse_dma;
      @(posedge pclk);
      dma_event <= 1'b1;
      @(posedge pclk);
      dma_event <= 1'b0;
   endtask : pulse_dma
endmodule : gpio_pin_model

// ==== gpio_port_interrupt_and_pad_config_tb.sv ====
// Testbench: registers, triggers, DMA, pads and lock
module gpio_port_interrupt_and_pad_config_tb import gpio_port_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   // Raw bit per trigger code after rise, fall
   localparam logic [4:0] HI_EXP = 5'h16;
   localparam logic [4:0] LO_EXP = 5'h0d;

   logic              pclk, presetn, psel, penable, pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic              pready, pslverr, dma_event, port_irq, err_q;
   logic [7:0]        pin_in, pin_irq;
   pad_cfg_t          pad_cfg [PIN_COUNT];
   pad_ctl_t          pad_ctl [PIN_COUNT];
   int                err_count, cmp_count;

   // 20 MHz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   gpio_port DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .dma_event(dma_event), .pad_cfg(pad_cfg), .pad_ctl(pad_ctl),
      .port_irq(port_irq), .pin_irq(pin_irq));

   gpio_pin_model pins (.pclk(pclk), .pin_in(pin_in), .dma_event(dma_event));

   task automatic conclude;
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // One APB transfer after an idle edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         err_count++;
         $display("CHECK FAILED pready expected 1 seen %b", pready);
         conclude();
      end
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string name);
      logic [31:0] q;
      xfer(a, 1'b0, 32'h0, q);
      check(name, e, q);
   endtask : rd_chk

   initial begin : main
      logic [31:0] q;
      logic [31:0] t;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, refused access
      rd_chk(OFS_INT_ENABLE, 32'h0, "enable reset");
      rd_chk(OFS_TRIG_CFG, 32'h0, "trig reset");
      rd_chk(OFS_LOCK, 32'h1, "lock reset");
      rd_chk(OFS_COMMIT, 32'hf0, "commit reset");
      rd_chk(OFS_INT_CLEAR, 32'h0, "clear reads");
      xfer(8'h40, 1'b0, 32'h0, q);
      check("unmapped error", 32'h1, {31'h0, err_q});
      // Each trigger code on pin 1; option on last
      wr(OFS_INT_ENABLE, 32'h002);
      wr(OFS_PIN_SELECT, 32'h02);
      wr(OFS_PIN_INDEX, 32'h1);
      for (int i = 0; i < 5; i++) begin
         t = (i == 4) ? 32'(i) | 32'h8 : 32'(i);
         wr(OFS_TRIG_CFG, t);
         rd_chk(OFS_TRIG_CFG, t, "trig readback");
         wr(OFS_INT_CLEAR, 32'h1ff);
         pins.drive_pins(8'h02);
         repeat (4) @(posedge pclk);
         rd_chk(OFS_RAW_STATUS, {HI_EXP[i], 1'b0}, "raw rise");
         rd_chk(OFS_MSK_STATUS, {HI_EXP[i], 1'b0}, "masked rise");
         @(negedge pclk);
         check("port irq", {31'h0, HI_EXP[i]}, {31'h0, port_irq});
         check("pin 1 line", {31'h0, HI_EXP[i]}, {31'h0, pin_irq[1]});
         check("pin 0 line", (i == 4) ? 32'h0 : {31'h0, HI_EXP[i]}, {31'h0, pin_irq[0]});
         wr(OFS_INT_CLEAR, 32'h002);
         pins.drive_pins(8'h00);
         repeat (4) @(posedge pclk);
         rd_chk(OFS_RAW_STATUS, {LO_EXP[i], 1'b0}, "raw fall");
      end
      // DMA source, then masked off
      wr(OFS_INT_ENABLE, 32'h100);
      pins.pulse_dma();
      rd_chk(OFS_RAW_STATUS, 32'h100, "dma raw");
      wr(OFS_INT_ENABLE, 32'h000);
      rd_chk(OFS_MSK_STATUS, 32'h0, "dma masked");
      @(negedge pclk);
      check("disabled irq", 32'h0, {31'h0, port_irq});
      wr(OFS_INT_CLEAR, 32'h100);
      rd_chk(OFS_RAW_STATUS, 32'h0, "dma cleared");
      // All pad codes on pin 7; pin 0 locked
      wr(OFS_PIN_SELECT, 32'h81);
      wr(OFS_PIN_INDEX, 32'h7);
      for (int i = 0; i < 7; i++) begin
         wr(OFS_PAD_CFG, 32'(i * 17));
         rd_chk(OFS_PAD_CFG, 32'(i * 17), "pad readback");
      end
      wr(OFS_PAD_CFG, 32'h37);
      rd_chk(OFS_PAD_CFG, 32'h66, "illegal drive");
      wr(OFS_PAD_CFG, 32'h33);
      @(posedge pclk);
      @(negedge pclk);
      check("pad 7 port", 32'h1b, {26'h0, pad_cfg[7]});
      check("pad 7 ctl", 32'h3, {30'h0, pad_ctl[7].open_drain, pad_ctl[7].slew_limit});
      check("pad 0 locked", 32'h0, {26'h0, pad_cfg[0]});
      // Unlock, commit, then pin 0 takes it
      wr(OFS_LOCK, RST_UNLOCK_KEY);
      rd_chk(OFS_LOCK, 32'h0, "unlocked");
      wr(OFS_COMMIT, 32'hff);
      wr(OFS_PIN_INDEX, 32'h0);
      wr(OFS_PAD_CFG, 32'h16);
      rd_chk(OFS_PAD_CFG, 32'h16, "pad 0 committed");
      @(negedge pclk);
      check("pad 0 pullup", 32'h1, {31'h0, pad_ctl[0].pull_up});
      wr(OFS_LOCK, 32'h0);
      wr(OFS_COMMIT, 32'h00);
      rd_chk(OFS_COMMIT, 32'hff, "commit locked");
      conclude();
   end
endmodule : gpio_port_interrupt_and_pad_config_tb

bind gpio_port gpio_port_monitor mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pin_in(pin_in), .dma_event(dma_event), .pad_cfg(pad_cfg), .pad_ctl(pad_ctl),
   .port_irq(port_irq), .pin_irq(pin_irq));
